// *** hw/cbc_top.sv ***
`timescale 1ns/100ps
// What this block does
// - write-back flush: write back, invalidate, two acks
// - write-through flush only invalidates, no ack
// - one-clock flush pulse is a full request
// - flush low before reset release: tri-state test
// - snoop modified hit: snoop_hit_modified_n low two clocks later
// - snoop_hit_modified_n low until first burst ready, else high
// - write-through: snoop_hit_modified_n never driven
// - hold ack with bus float, floats only in test
// - hold: finish cycle or lock, then release bus
// - ignore-error low continues fp, high freezes
// - irq with flag: two locked acknowledge cycles
// - invalidate sampled with strobe, ignored write-through
// - cache enable low before ready makes fill
// - cache enable low before last ready stores line
// - lock blocks hold, no locked fills
// - lock spans first to last locked cycle
// - nmi rising edge after four low clocks
// - page cache disable follows bit, masked, paging
// - page write-through follows bit, low without paging
// - parity error low one clock after read ready
// - pseudo lock high write-back, low multi-cycle write-through
// - memory high, io low
// - snoop strobe accepted only in hold/backoff/address_hold
`include "cbc_map.svh"
module cbc_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic flush_n_i,
   input wire logic writeback_select_i,
   input wire logic hold_req_i,
   input wire logic address_hold_i,
   input wire logic back_off_n_i,
   input wire logic snoop_addr_strobe_n_i,
   input wire logic snoop_invalidate_i,
   input wire logic ready_n_i,
   input wire logic burst_ready_n_i,
   input wire logic cacheable_enable_n_i,
   input wire logic ignore_numeric_err_n_i,
   input wire logic maskable_irq_i,
   input wire logic nmi_i,
   input wire logic [31:0] data_i,
   input wire logic [3:0] data_parity_lines_i,
   input wire logic [3:0] byte_en_n_i,
   output logic snoop_hit_modified_n_o,
   output logic snoop_hit_modified_n_oe_o,
   output logic hold_ack_o,
   output logic hold_ack_oe_o,
   output logic bus_float_o,
   output logic bus_lock_n_o,
   output logic pseudo_locked_n_o,
   output logic mem_io_o,
   output logic page_cache_disable_o,
   output logic page_write_through_o,
   output logic parity_status_n_o,
   output logic parity_status_n_oe_o,
   output logic flush_ack_cycle_o,
   output logic inta_cycle_o,
   output logic cache_inval_o,
   output logic snoop_inval_o,
   output logic line_fill_o,
   output logic line_store_o,
   output logic fp_freeze_o,
   output logic nmi_taken_o
);
   import cbc_pkg::*;

   typedef struct packed {
      cbc_state_e st;
      logic [1:0] flush_s, igne_s, irq_s, nmi_s;
      logic [1:0] wbs_s;
      logic flush_pend, test_mode, wb_mode;
      logic [31:0] ctrl, cmd, page;
      logic [31:0] rdat;
      logic ack;
      logic [1:0] cnt, snoop_hit_modified_n_cnt;
      logic snoop_hit_modified_n_n, snoop_hit_modified_n_oe, snoop_hit_modified_n_wait;
      logic hold_ack, flt, lock_n, pseudo_locked_n_n, mio, page_cache_disable, page_write_through;
      logic parity_status_n_n, rd_done;
      logic fack, inta, inval, sinv, fill, fill_act, store, frz;
      logic [2:0] nmi_low;
      logic nmi_tk;
      logic in_cyc, ken_q;
   } cbc_state_s;

   cbc_state_s q, d;

   function automatic logic is_reg(input logic [3:0] a, input logic [3:0] r);
      is_reg = (a == r);
   endfunction : is_reg

   logic wb_req, snoop_ok, rdy_any, par_err;
   always_comb begin
      wb_req = wb_cyc_i && wb_stb_i && !q.ack;
      snoop_ok = q.hold_ack || !back_off_n_i || address_hold_i;
      rdy_any = !ready_n_i || !burst_ready_n_i;
      par_err = 1'b0;
      for (int i = 0; i < 4; i++) begin
         if (!byte_en_n_i[i] && (^{data_i[8*i +: 8], data_parity_lines_i[i]}))
            par_err = 1'b1;
      end
   end

   always_comb begin
      d = q;
      d.ack = wb_req;
      d.fack = 1'b0;
      d.inta = 1'b0;
      d.inval = 1'b0;
      d.sinv = 1'b0;
      d.fill = 1'b0;
      d.store = 1'b0;
      d.nmi_tk = 1'b0;
      d.rd_done = 1'b0;
      // two-stage synchronisers
      d.flush_s = {q.flush_s[0], flush_n_i};
      d.igne_s = {q.igne_s[0], ignore_numeric_err_n_i};
      d.irq_s = {q.irq_s[0], maskable_irq_i};
      d.nmi_s = {q.nmi_s[0], nmi_i};
      // mode strap is a pin as well, so it is synchronised before capture
      d.wbs_s = {q.wbs_s[0], writeback_select_i};
      if (wb_req && wb_we_i) begin
         if (is_reg(wb_adr_i, `CBC_REG_CTRL)) d.ctrl = wb_dat_i;
         if (is_reg(wb_adr_i, `CBC_REG_CMD)) d.cmd = wb_dat_i;
         if (is_reg(wb_adr_i, `CBC_REG_PAGE)) d.page = wb_dat_i;
      end
      d.rdat = 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
         if (is_reg(wb_adr_i, `CBC_REG_CTRL)) d.rdat = q.ctrl;
         if (is_reg(wb_adr_i, `CBC_REG_CMD)) d.rdat = q.cmd;
         if (is_reg(wb_adr_i, `CBC_REG_PAGE)) d.rdat = q.page;
         if (is_reg(wb_adr_i, `CBC_REG_STAT))
            d.rdat = {24'h000000, q.test_mode, q.wb_mode, q.lock_n, q.hold_ack,
                      q.snoop_hit_modified_n_n, q.flush_pend, q.frz, q.pseudo_locked_n_n};
      end
      // synchronised flush: a single low sample latches a request
      if (!q.flush_s[1]) d.flush_pend = 1'b1;
      // nmi rising edge after at least four low clocks
      if (!q.nmi_s[1]) begin
         if (q.nmi_low != `CBC_NMI_LOW_MIN) d.nmi_low = q.nmi_low + 3'd1;
      end else begin
         d.nmi_low = 3'd0;
         if (q.nmi_low == `CBC_NMI_LOW_MIN) d.nmi_tk = 1'b1;
      end
      d.frz = q.cmd[`CBC_CMD_FPERR] && q.cmd[`CBC_CMD_FPINS] &&
              !q.ctrl[`CBC_CTRL_NE] && q.igne_s[1];
      // bus cycle tracking and lock
      if (rdy_any) d.in_cyc = 1'b0;
      d.ken_q = cacheable_enable_n_i;
      case (q.st)
         CBC_IDLE: begin
            if (q.flush_pend) begin
               d.flush_pend = !q.flush_s[1];
               d.st = q.wb_mode ? CBC_WBACK : CBC_INVAL;
            end else if (hold_req_i && q.lock_n) begin
               d.st = CBC_HOLD;
               d.hold_ack = 1'b1;
               d.flt = 1'b1;
            end else if (q.irq_s[1] && q.ctrl[`CBC_CTRL_IF]) begin
               d.st = CBC_INTA;
               d.cnt = `CBC_INTA_CYCLES;
               d.lock_n = 1'b0;
            end else begin
               d.lock_n = !q.cmd[`CBC_CMD_LOCK];
            end
         end
         CBC_WBACK: begin
            d.cmd[`CBC_CMD_MOD] = 1'b0;
            d.st = CBC_INVAL;
         end
         CBC_INVAL: begin
            d.inval = 1'b1;
            d.cnt = `CBC_FLUSH_ACKS;
            d.st = q.wb_mode ? CBC_FACK : CBC_IDLE;
         end
         CBC_FACK: begin
            d.fack = 1'b1;
            d.cnt = q.cnt - 2'd1;
            if (q.cnt == 2'd1) d.st = CBC_IDLE;
         end
         CBC_INTA: begin
            d.inta = 1'b1;
            if (!ready_n_i) begin
               d.cnt = q.cnt - 2'd1;
               if (q.cnt == 2'd1) begin
                  d.st = CBC_IDLE;
                  d.lock_n = 1'b1;
                  // interrupt entry masks further maskable requests
                  d.ctrl[`CBC_CTRL_IF] = 1'b0;
               end
            end
         end
         CBC_HOLD: begin
            if (!hold_req_i) begin
               d.st = CBC_IDLE;
               d.hold_ack = 1'b0;
               d.flt = 1'b0;
            end
         end
         default: d.st = CBC_IDLE;
      endcase
      // line fill and store decisions
      if (rdy_any && !q.ken_q && q.lock_n) begin
         if (!q.fill_act) begin
            d.fill = 1'b1;
            d.fill_act = 1'b1;
         end else if (!ready_n_i) begin
            d.store = 1'b1;
            d.fill_act = 1'b0;
         end
      end
      if (!q.lock_n) d.fill_act = 1'b0;
      // snoop: invalidate sampled with strobe, hit-modified two clocks later
      if (!snoop_addr_strobe_n_i && snoop_ok && q.snoop_hit_modified_n_n && q.snoop_hit_modified_n_cnt == 2'd0) begin
         d.sinv = snoop_invalidate_i && q.wb_mode;
         if (q.wb_mode && q.cmd[`CBC_CMD_MOD]) d.snoop_hit_modified_n_cnt = `CBC_SNOOP_HIT_MODIFIED_N_DLY - 2'd1;
      end
      if (q.snoop_hit_modified_n_cnt != 2'd0) begin
         d.snoop_hit_modified_n_cnt = q.snoop_hit_modified_n_cnt - 2'd1;
         if (q.snoop_hit_modified_n_cnt == 2'd1) begin
            d.snoop_hit_modified_n_n = 1'b0;
            d.snoop_hit_modified_n_wait = 1'b1;
         end
      end
      if (q.snoop_hit_modified_n_wait && !burst_ready_n_i) begin
         d.snoop_hit_modified_n_n = 1'b1;
         d.snoop_hit_modified_n_wait = 1'b0;
      end
      // test mode keeps the bus floating whatever the hold logic does
      if (q.test_mode) d.flt = 1'b1;
      d.snoop_hit_modified_n_oe = q.wb_mode && !q.test_mode;
      d.pseudo_locked_n_n = q.wb_mode ? 1'b1 : !q.page[`CBC_PAGE_MULTI];
      d.mio = !q.page[`CBC_PAGE_IO];
      d.page_cache_disable = q.ctrl[`CBC_CTRL_PG] && q.page[`CBC_PAGE_PCD] &&
              !q.ctrl[`CBC_CTRL_CD];
      d.page_write_through = q.ctrl[`CBC_CTRL_PG] && q.page[`CBC_PAGE_PWT];
      d.parity_status_n_n = !(!ready_n_i && q.in_cyc && par_err);
      if (!ready_n_i || !burst_ready_n_i) d.in_cyc = 1'b0;
      if (!q.flt && q.st == CBC_IDLE) d.in_cyc = 1'b1;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.st <= CBC_IDLE;
         q.flush_s <= {q.flush_s[0], flush_n_i};
         q.wbs_s <= {q.wbs_s[0], writeback_select_i};
         q.igne_s <= 2'b11;
         q.ctrl <= `CBC_CTRL_RST;
         q.snoop_hit_modified_n_n <= 1'b1;
         q.lock_n <= 1'b1;
         q.pseudo_locked_n_n <= 1'b1;
         q.mio <= 1'b1;
         q.parity_status_n_n <= 1'b1;
         q.ken_q <= 1'b1;
         // both strap chains keep running in reset, the last reset clock wins
         q.wb_mode <= q.wbs_s[1];
         q.test_mode <= !q.flush_s[1];
         q.flt <= !q.flush_s[1];
      end else begin
         q <= d;
      end
   end

   always_comb begin
      wb_dat_o = q.rdat;
      wb_ack_o = q.ack;
      snoop_hit_modified_n_o = q.snoop_hit_modified_n_n;
      snoop_hit_modified_n_oe_o = q.snoop_hit_modified_n_oe;
      hold_ack_o = q.hold_ack;
      hold_ack_oe_o = !q.test_mode;
      bus_float_o = q.flt;
      bus_lock_n_o = q.lock_n;
      pseudo_locked_n_o = q.pseudo_locked_n_n;
      mem_io_o = q.mio;
      page_cache_disable_o = q.page_cache_disable;
      page_write_through_o = q.page_write_through;
      parity_status_n_o = q.parity_status_n_n;
      parity_status_n_oe_o = !q.test_mode;
      flush_ack_cycle_o = q.fack;
      inta_cycle_o = q.inta;
      cache_inval_o = q.inval;
      snoop_inval_o = q.sinv;
      line_fill_o = q.fill;
      line_store_o = q.store;
      fp_freeze_o = q.frz;
      nmi_taken_o = q.nmi_tk;
   end

   a_snoop_hit_modified_n_delay: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(snoop_hit_modified_n_o) |-> $past(!snoop_addr_strobe_n_i, 2))
      else $error("snoop_hit_modified_n timing");
   a_snoop_hit_modified_n_float: assert property (@(posedge clk_i) disable iff (rst_i)
      !q.wb_mode |-> ##1 !snoop_hit_modified_n_oe_o) else $error("snoop_hit_modified_n driven");
   a_snoop_hit_modified_n_drive: assert property (@(posedge clk_i) disable iff (rst_i)
      q.wb_mode && !q.test_mode |-> ##1 snoop_hit_modified_n_oe_o) else $error("snoop_hit_modified_n float");
   a_fack_wt: assert property (@(posedge clk_i) disable iff (rst_i)
      !q.wb_mode |-> !flush_ack_cycle_o) else $error("flush ack in wt");
   a_flush_acks: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(flush_ack_cycle_o) |-> flush_ack_cycle_o [*2] ##1 !flush_ack_cycle_o)
      else $error("flush ack count");
   a_fack_inval: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(flush_ack_cycle_o) |-> $past(cache_inval_o)) else $error("ack before inval");
   a_hold_lock: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(hold_ack_o) |-> $past(bus_lock_n_o)) else $error("hold under lock");
   a_hold_ack_float: assert property (@(posedge clk_i) disable iff (rst_i)
      hold_ack_o |-> bus_float_o) else $error("hold_ack without float");
   a_pcd_mask: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(q.ctrl[`CBC_CTRL_CD]) |-> !page_cache_disable_o) else $error("pcd mask");
   a_pwt_nopg: assert property (@(posedge clk_i) disable iff (rst_i)
      !$past(q.ctrl[`CBC_CTRL_PG]) |-> !page_write_through_o) else $error("pwt paging");
   a_pseudo_locked_n_wb: assert property (@(posedge clk_i) disable iff (rst_i)
      q.wb_mode |-> ##1 pseudo_locked_n_o) else $error("pseudo_locked_n in wb");
   a_parity_status_n_ready: assert property (@(posedge clk_i) disable iff (rst_i)
      !parity_status_n_o |-> $past(!ready_n_i)) else $error("parity_status_n timing");
   a_mio_io: assert property (@(posedge clk_i) disable iff (rst_i)
      mem_io_o == !$past(q.page[`CBC_PAGE_IO])) else $error("mio level");
   a_sinv_wt: assert property (@(posedge clk_i) disable iff (rst_i)
      !q.wb_mode |-> ##1 !snoop_inval_o) else $error("invalidate in wt");
   a_lock_nofill: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(!q.lock_n) |-> !line_fill_o) else $error("locked fill");
   a_inta_locked: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(inta_cycle_o) |-> !bus_lock_n_o) else $error("inta unlocked");
   a_nmi_edge: assert property (@(posedge clk_i) disable iff (rst_i)
      nmi_taken_o |-> $past(q.nmi_s[1]) && !$past(q.nmi_s[1], 2) && !$past(q.nmi_s[1], 5))
      else $error("nmi edge");
   c_flush_wb: cover property (@(posedge clk_i) disable iff (rst_i) $rose(flush_ack_cycle_o));
   c_hold: cover property (@(posedge clk_i) disable iff (rst_i) $rose(hold_ack_o));
   c_snoop_hit_modified_n: cover property (@(posedge clk_i) disable iff (rst_i) $fell(snoop_hit_modified_n_o));
   c_inta: cover property (@(posedge clk_i) disable iff (rst_i) $rose(inta_cycle_o));
   c_store: cover property (@(posedge clk_i) disable iff (rst_i) $rose(line_store_o));
endmodule : cbc_top

// *** hw/cbc_map.svh ***
`ifndef CBC_MAP_SVH
`define CBC_MAP_SVH
// register word offsets (byte addresses)
`define CBC_REG_CTRL 4'h0
`define CBC_REG_STAT 4'h4
`define CBC_REG_CMD 4'h8
`define CBC_REG_PAGE 4'hc
// control register fields
`define CBC_CTRL_IF 0
`define CBC_CTRL_NE 1
`define CBC_CTRL_CD 2
`define CBC_CTRL_PG 3
`define CBC_CTRL_RST 32'h0000_0000
// command register fields
`define CBC_CMD_MOD 0
`define CBC_CMD_FPERR 1
`define CBC_CMD_FPINS 2
`define CBC_CMD_LOCK 3
// page register fields
`define CBC_PAGE_PCD 0
`define CBC_PAGE_PWT 1
`define CBC_PAGE_IO 2
`define CBC_PAGE_MULTI 3
// timing counts
`define CBC_SNOOP_HIT_MODIFIED_N_DLY 2'd2
`define CBC_FLUSH_ACKS 2'd2
`define CBC_INTA_CYCLES 2'd2
`define CBC_NMI_LOW_MIN 3'd4
`endif

// *** hw/cbc_pkg.sv ***
package cbc_pkg;
   typedef enum logic [2:0] {
      CBC_IDLE = 3'b000,
      CBC_WBACK = 3'b001,
      CBC_INVAL = 3'b010,
      CBC_FACK = 3'b011,
      CBC_INTA = 3'b100,
      CBC_HOLD = 3'b101
   } cbc_state_e;
endpackage : cbc_pkg

// *** tb/cbc_chipset.sv ***
`timescale 1ns/100ps
module cbc_chipset (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic inta_cycle_i,
   input wire logic irq_req_i,
   input wire logic nmi_req_i,
   input wire logic rdy_req_i,
   output logic ready_n_o,
   output logic [31:0] data_o,
   output logic [3:0] parity_o,
   output logic irq_o,
   output logic nmi_o
);
   logic [1:0] acks_q;
   logic [2:0] low_q;
   // data changes every clock, parity always travels with it
   always_comb for (int i = 0; i < 4; i++) parity_o[i] = ^data_o[8*i +: 8];
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ready_n_o <= 1'b1;
         irq_o <= 1'b0;
         nmi_o <= 1'b0;
         acks_q <= 2'h0;
         low_q <= 3'h0;
         data_o <= 32'h5a5a_0ff0;
      end else begin
         data_o <= ~data_o;
         // answer an acknowledge or a requested read every other clock
         ready_n_o <= !((inta_cycle_i || rdy_req_i) && ready_n_o);
         if (!ready_n_o && acks_q != 2'h2) acks_q <= acks_q + 2'h1;
         if (irq_req_i && !irq_o) begin
            irq_o <= 1'b1;
            acks_q <= 2'h0;
         end else if (acks_q == 2'h2) begin
            irq_o <= 1'b0;
         end
         low_q <= nmi_o ? 3'h0 : low_q + {2'h0, low_q != 3'h7};
         nmi_o <= nmi_req_i && (nmi_o || low_q >= 3'h4);
      end
   end
endmodule : cbc_chipset

// *** tb/testbench.sv ***
`timescale 1ns/100ps
`include "cbc_map.svh"
module testbench;
   logic clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf, byte_en_n_i = 4'h0, data_parity_lines_i;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, data_i, lfsr = 32'hadd1;
   logic flush_n_i = 1'b1, writeback_select_i = 1'b1, hold_req_i = 1'b0, address_hold_i = 1'b0;
   logic back_off_n_i = 1'b1, snoop_addr_strobe_n_i = 1'b1, snoop_invalidate_i = 1'b0;
   logic burst_ready_n_i = 1'b1, cacheable_enable_n_i = 1'b1, ignore_numeric_err_n_i = 1'b1;
   logic ready_n_i, maskable_irq_i, nmi_i, irq_req = 1'b0, nmi_req = 1'b0, rdy_req = 1'b0;
   logic wb_ack_o, snoop_hit_modified_n_o, snoop_hit_modified_n_oe_o, hold_ack_o, hold_ack_oe_o;
   logic bus_float_o, bus_lock_n_o, pseudo_locked_n_o, mem_io_o, page_cache_disable_o;
   logic page_write_through_o, parity_status_n_o, parity_status_n_oe_o, flush_ack_cycle_o;
   logic inta_cycle_o, cache_inval_o, snoop_inval_o, line_fill_o, line_store_o, fp_freeze_o;
   logic nmi_taken_o;
   logic [31:0] exp_q[$];
   int fail_count = 0, n_tests = 0, n_a, cnt[9];
   cbc_top dut_u (.*);
   cbc_chipset far_u (.clk_i(clk_i), .rst_i(rst_i), .inta_cycle_i(inta_cycle_o),
      .irq_req_i(irq_req), .nmi_req_i(nmi_req), .rdy_req_i(rdy_req), .ready_n_o(ready_n_i),
      .data_o(data_i), .parity_o(data_parity_lines_i), .irq_o(maskable_irq_i), .nmi_o(nmi_i));
   always #2.5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cnt[0] += flush_ack_cycle_o;
      cnt[1] += cache_inval_o;
      cnt[2] += nmi_taken_o;
      cnt[3] += inta_cycle_o && !ready_n_i;
      cnt[4] += inta_cycle_o && !ready_n_i && !bus_lock_n_o;
      cnt[5] += snoop_inval_o;
      cnt[6] += !parity_status_n_o;
      cnt[7] += line_fill_o;
      cnt[8] += line_store_o;
      if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i) chk(wb_dat_o, exp_q.pop_front());
   end
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : nxt
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic give_verdict();
      if (fail_count == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   task automatic wb(input logic [3:0] a, input logic we, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_adr_i <= a;
      wb_we_i <= we;
      wb_dat_i <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      wb(a, 1'b0, 32'h0);
   endtask : rd
   task automatic do_reset(input logic mode, input logic fl);
      @(posedge clk_i);
      rst_i <= 1'b1;
      writeback_select_i <= mode;
      flush_n_i <= fl;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      flush_n_i <= 1'b1;
      @(posedge clk_i);
   endtask : do_reset
   task automatic flush_chk(input int acks);
      @(posedge clk_i);
      flush_n_i <= 1'b0;
      @(posedge clk_i);
      flush_n_i <= 1'b1;
      #1 cnt = '{default:0};
      repeat (60) @(posedge clk_i);
      #1 chk(cnt[0], acks);
      chk(cnt[1], 1);
   endtask : flush_chk
   task automatic strobe();
      @(posedge clk_i);
      snoop_addr_strobe_n_i <= 1'b0;
      snoop_invalidate_i <= lfsr[0];
      @(posedge clk_i);
      snoop_addr_strobe_n_i <= 1'b1;
   endtask : strobe
   initial begin
      #100000;
      fail_count++;
      give_verdict();
   end
   initial begin
      do_reset(1'b0, 1'b0);
      #1 chk(bus_float_o, 1);
      chk(hold_ack_oe_o, 0);
      chk(parity_status_n_oe_o, 0);
      do_reset(1'b0, 1'b1);
      #1 chk(snoop_hit_modified_n_oe_o, 0);
      flush_chk(0);
      wb(`CBC_REG_PAGE, 1'b1, 32'h8);
      #1 chk(pseudo_locked_n_o, 0);
      do_reset(1'b1, 1'b1);
      #1 chk({snoop_hit_modified_n_o, snoop_hit_modified_n_oe_o}, 3);
      flush_chk(2);
      rd(`CBC_REG_CTRL, `CBC_CTRL_RST);
      rd(4'h1, 32'h0);
      for (int i = 0; i < 8; i++) begin
         lfsr = nxt(lfsr);
         wb(`CBC_REG_CTRL, 1'b1, {28'h0, lfsr[3:2], 2'b00});
         wb(`CBC_REG_PAGE, 1'b1, {28'h0, lfsr[7:4]});
         rd(`CBC_REG_PAGE, {28'h0, lfsr[7:4]});
         #1 chk(page_cache_disable_o, lfsr[3] & lfsr[4] & !lfsr[2]);
         chk(page_write_through_o, lfsr[3] & lfsr[5]);
         chk(mem_io_o, !lfsr[6]);
         chk(pseudo_locked_n_o, 1);
      end
      wb(`CBC_REG_CMD, 1'b1, 32'h1);
      strobe();
      repeat (4) @(posedge clk_i);
      #1 chk(snoop_hit_modified_n_o, 1);
      @(posedge clk_i) hold_req_i <= 1'b1;
      for (n_a = 0; n_a < 50 && hold_ack_o !== 1'b1; n_a++) @(posedge clk_i);
      #1 chk(bus_float_o, 1);
      cnt = '{default:0};
      strobe();
      for (n_a = 1; n_a < 9 && snoop_hit_modified_n_o !== 1'b0; n_a++) @(posedge clk_i);
      chk(n_a, 3);
      #1 chk(snoop_hit_modified_n_o, 0);
      @(posedge clk_i) burst_ready_n_i <= 1'b0;
      @(posedge clk_i) burst_ready_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1 chk(snoop_hit_modified_n_o, 1);
      chk(cnt[5], lfsr[0]);
      @(posedge clk_i) hold_req_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      #1 chk(hold_ack_o, 0);
      for (int f = 0; f < 2; f++) begin
         wb(`CBC_REG_CTRL, 1'b1, f);
         #1 cnt = '{default:0};
         @(posedge clk_i) irq_req <= 1'b1;
         @(posedge clk_i) irq_req <= 1'b0;
         repeat (40) @(posedge clk_i);
         #1 chk(cnt[3], 2 * f);
         chk(cnt[4], 2 * f);
         chk(cnt[6], 0);
      end
      cnt = '{default:0};
      @(posedge clk_i) cacheable_enable_n_i <= 1'b0;
      @(posedge clk_i) burst_ready_n_i <= 1'b0;
      @(posedge clk_i) begin
         burst_ready_n_i <= 1'b1;
         rdy_req <= 1'b1;
      end
      @(posedge clk_i) rdy_req <= 1'b0;
      repeat (3) @(posedge clk_i);
      cacheable_enable_n_i <= 1'b1;
      #1 chk(cnt[7], 1);
      chk(cnt[8], 1);
      chk(cnt[6], 0);
      cnt = '{default:0};
      @(posedge clk_i) nmi_req <= 1'b1;
      repeat (8) @(posedge clk_i);
      nmi_req <= 1'b0;
      repeat (8) @(posedge clk_i);
      #1 chk(cnt[2], 1);
      wb(`CBC_REG_CMD, 1'b1, 32'h6);
      for (int k = 0; k < 3; k++) begin
         @(posedge clk_i) ignore_numeric_err_n_i <= (k != 0);
         wb(`CBC_REG_CTRL, 1'b1, (k == 1) ? 32'h2 : 32'h0);
         repeat (4) @(posedge clk_i);
         #1 chk(fp_freeze_o, k == 2);
      end
      give_verdict();
   end
endmodule : testbench
